/* File: rtl/reg_access_cfg.svh */
// constants for the serial register access port: addresses, offsets, resets, timing
// assumes nothing; included by the package and by every design file except the link interface
`ifndef REG_ACCESS_CFG_SVH
`define REG_ACCESS_CFG_SVH

`define DEV_ADDR_BYTE_WR 8'h66
`define DEV_ADDR_BYTE_RD 8'h67
`define CTL_OFFSET 8'h23
`define CTL_RESET 4'h5
`define CTL_AUTOV_NOW 3
`define CTL_AUTOV_FRAME 2
`define CTL_AEV_NOW 1
`define CTL_AEV_FRAME 0
`define AEV_BASE 8'h40
`define AUTOV_BASE 8'h50
`define SYNC_SPAN 16
`define CLK_PERIOD_NS 25
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/reg_access_pkg.sv */
// types shared by both ends of the serial register access link
// assumes reg_access_cfg.svh on the include path
`include "reg_access_cfg.svh"
package reg_access_pkg;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_ACK_ADDR = 9'h004,
        S_REGADR = 9'h008,
        S_ACK_REG = 9'h010,
        S_WDATA = 9'h020,
        S_ACK_DATA = 9'h040,
        S_RDATA = 9'h080,
        S_RACK = 9'h100
    } slave_state_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_BIT = 4'h4,
        M_STOP = 4'h8
    } master_state_t;

    typedef enum logic [4:0] {
        K_ADDRW = 5'h01,
        K_REG = 5'h02,
        K_DATA = 5'h04,
        K_ADDRR = 5'h08,
        K_READ = 5'h10
    } byte_kind_t;

    typedef enum logic [2:0] {
        C_REGULAR = 3'h1,
        C_AEV = 3'h2,
        C_AUTOV = 3'h4
    } reg_class_t;

    function automatic reg_class_t reg_class(input logic [7:0] a);
        if (a >= `AEV_BASE && a < `AEV_BASE + `SYNC_SPAN) begin
            return C_AEV;
        end else if (a >= `AUTOV_BASE && a < `AUTOV_BASE + `SYNC_SPAN) begin
            return C_AUTOV;
        end else begin
            return C_REGULAR;
        end
    endfunction

endpackage

/* File: rtl/i2c_link_if.sv */
// two-wire link between the host end and the sensor end, with pull-up resolution
// assumes open-drain drivers: an enable low with output low pulls the wire down
`timescale 1ns/1ps
interface i2c_link_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl_line;
    logic sda_line;

    assign scl_line = !(!m_scl_oe_n && !m_scl_o);
    assign sda_line = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));

    modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n,
                    input scl_line, input sda_line);
    modport slave (output s_sda_o, output s_sda_oe_n, input scl_line, input sda_line);
endinterface

/* File: rtl/reg_bank.sv */
// register storage with regular and frame-synchronised commit classes
// assumes writes come from the serial port on the same clock
`timescale 1ns/1ps
`include "reg_access_cfg.svh"
module reg_bank (
    input wire logic clock,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic [7:0] user_addr,
    output logic [7:0] user_data,
    input wire logic aev_event,
    input wire logic autov_event,
    output logic aev_commit,
    output logic autov_commit,
    output logic [3:0] ctl
);
    typedef struct packed {
        logic [255:0][7:0] act;
        logic [15:0][7:0] aev_sh;
        logic [15:0][7:0] autov_sh;
        logic [3:0] ctl;
        logic aev_commit;
        logic autov_commit;
        logic [7:0] user_data;
    } bank_t;

    bank_t r;
    bank_t n;
    logic aev_upd;
    logic autov_upd;

    // commit strobes from the control field
    assign autov_upd = r.ctl[`CTL_AUTOV_NOW] || (autov_event && r.ctl[`CTL_AUTOV_FRAME]);
    assign aev_upd = r.ctl[`CTL_AEV_NOW] || (aev_event && r.ctl[`CTL_AEV_FRAME]);

    always_comb begin
        n = r;
        n.aev_commit = aev_upd;
        n.autov_commit = autov_upd;
        for (int i = 0; i < `SYNC_SPAN; i++) begin
            if (aev_upd) begin
                n.act[`AEV_BASE + i] = r.aev_sh[i];
            end
            if (autov_upd) begin
                n.act[`AUTOV_BASE + i] = r.autov_sh[i];
            end
        end
        if (wr_en) begin
            if (wr_addr == `CTL_OFFSET) begin
                n.ctl = wr_data[3:0];
            end else if (reg_access_pkg::reg_class(wr_addr) == reg_access_pkg::C_AEV) begin
                n.aev_sh[wr_addr[3:0]] = wr_data;
            end else if (reg_access_pkg::reg_class(wr_addr) == reg_access_pkg::C_AUTOV) begin
                n.autov_sh[wr_addr[3:0]] = wr_data;
            end else begin
                n.act[wr_addr] = wr_data;
            end
        end
        n.user_data = (user_addr == `CTL_OFFSET) ? {4'h0, r.ctl} : r.act[user_addr];
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r <= '0;
            r.ctl <= `CTL_RESET;
        end else begin
            r <= n;
        end
    end

    assign rd_data = (rd_addr == `CTL_OFFSET) ? {4'h0, r.ctl} : r.act[rd_addr];
    assign user_data = r.user_data;
    assign aev_commit = r.aev_commit;
    assign autov_commit = r.autov_commit;
    assign ctl = r.ctl;
endmodule

/* File: rtl/i2c_sensor_port.sv */
// sensor end of the two-wire register access link, with its register bank
// assumes the host end generates the clock line and never stretches it
`timescale 1ns/1ps
`include "reg_access_cfg.svh"
module i2c_sensor_port (
    input wire logic clock,
    input wire logic reset,
    i2c_link_if.slave link,
    input wire logic aev_event,
    input wire logic autov_event,
    input wire logic [7:0] user_addr,
    output logic [7:0] user_data,
    output logic aev_commit,
    output logic autov_commit,
    output logic [3:0] ctl,
    output logic link_busy,
    output logic wr_strobe,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        reg_access_pkg::slave_state_t st;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic is_read;
        logic mack;
        logic sda_oe_n;
        logic busy;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } port_t;

    port_t r;
    port_t n;
    logic [7:0] rd_data;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // edges on synchronised lines; the first stage feeds only the second
    assign scl_rise = r.scl_s2 && !r.scl_s3;
    assign scl_fall = !r.scl_s2 && r.scl_s3;
    assign start_seen = r.scl_s2 && r.scl_s3 && r.sda_s3 && !r.sda_s2;
    assign stop_seen = r.scl_s2 && r.scl_s3 && !r.sda_s3 && r.sda_s2;

    always_comb begin
        n = r;
        n.scl_s1 = link.scl_line;
        n.scl_s2 = r.scl_s1;
        n.scl_s3 = r.scl_s2;
        n.sda_s1 = link.sda_line;
        n.sda_s2 = r.sda_s1;
        n.sda_s3 = r.sda_s2;
        n.wr_en = 1'b0;
        if (stop_seen) begin
            n.st = reg_access_pkg::S_IDLE;
            n.sda_oe_n = 1'b1;
            n.busy = 1'b0;
        end else if (start_seen) begin
            // a repeated start lands here too and keeps the stored pointer
            n.st = reg_access_pkg::S_ADDR;
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
            n.busy = 1'b1;
        end else begin
            case (r.st)
                reg_access_pkg::S_ADDR, reg_access_pkg::S_REGADR, reg_access_pkg::S_WDATA: begin
                    if (scl_rise) begin
                        n.shift = {r.shift[6:0], r.sda_s2};
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall && r.cnt == 4'h8) begin
                        n.cnt = 4'h0;
                        case (r.st)
                            reg_access_pkg::S_ADDR: begin
                                if (r.shift[7:1] == `DEV_ADDR_BYTE_WR >> 1) begin
                                    n.sda_oe_n = 1'b0;
                                    n.is_read = r.shift[0];
                                    n.st = reg_access_pkg::S_ACK_ADDR;
                                end else begin
                                    n.st = reg_access_pkg::S_IDLE;
                                    n.busy = 1'b0;
                                end
                            end
                            reg_access_pkg::S_REGADR: begin
                                n.sda_oe_n = 1'b0;
                                n.ptr = r.shift;
                                n.st = reg_access_pkg::S_ACK_REG;
                            end
                            default: begin
                                n.sda_oe_n = 1'b0;
                                n.wr_en = 1'b1;
                                n.wr_addr = r.ptr;
                                n.wr_data = r.shift;
                                n.st = reg_access_pkg::S_ACK_DATA;
                            end
                        endcase
                    end
                end
                reg_access_pkg::S_ACK_ADDR, reg_access_pkg::S_ACK_REG, reg_access_pkg::S_ACK_DATA: begin
                    if (scl_fall) begin
                        n.sda_oe_n = 1'b1;
                        n.cnt = 4'h0;
                        case (r.st)
                            reg_access_pkg::S_ACK_ADDR: begin
                                if (r.is_read) begin
                                    n.shift = rd_data;
                                    n.sda_oe_n = rd_data[7];
                                    n.cnt = 4'h1;
                                    n.st = reg_access_pkg::S_RDATA;
                                end else begin
                                    n.st = reg_access_pkg::S_REGADR;
                                end
                            end
                            reg_access_pkg::S_ACK_REG: begin
                                n.st = reg_access_pkg::S_WDATA;
                            end
                            default: begin
                                n.ptr = r.ptr + 8'h01;
                                n.st = reg_access_pkg::S_WDATA;
                            end
                        endcase
                    end
                end
                reg_access_pkg::S_RDATA: begin
                    if (scl_fall) begin
                        if (r.cnt == 4'h8) begin
                            n.sda_oe_n = 1'b1;
                            n.st = reg_access_pkg::S_RACK;
                        end else begin
                            n.sda_oe_n = r.shift[6];
                            n.shift = {r.shift[6:0], 1'b0};
                            n.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                reg_access_pkg::S_RACK: begin
                    if (scl_rise) begin
                        n.mack = !r.sda_s2;
                        if (!r.sda_s2) begin
                            n.ptr = r.ptr + 8'h01;
                        end
                    end
                    if (scl_fall) begin
                        if (r.mack) begin
                            n.shift = rd_data;
                            n.sda_oe_n = rd_data[7];
                            n.cnt = 4'h1;
                            n.st = reg_access_pkg::S_RDATA;
                        end else begin
                            n.st = reg_access_pkg::S_IDLE;
                        end
                    end
                end
                default: begin
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r <= '0;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.scl_s3 <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.sda_s3 <= 1'b1;
            r.st <= reg_access_pkg::S_IDLE;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    reg_bank bank (
        .clock(clock),
        .reset(reset),
        .wr_en(r.wr_en),
        .wr_addr(r.wr_addr),
        .wr_data(r.wr_data),
        .rd_addr(r.ptr),
        .rd_data(rd_data),
        .user_addr(user_addr),
        .user_data(user_data),
        .aev_event(aev_event),
        .autov_event(autov_event),
        .aev_commit(aev_commit),
        .autov_commit(autov_commit),
        .ctl(ctl)
    );

    assign link.s_sda_o = 1'b0;
    assign link.s_sda_oe_n = r.sda_oe_n;
    assign link_busy = r.busy;
    assign wr_strobe = r.wr_en;
    assign wr_addr = r.wr_addr;
    assign wr_data = r.wr_data;
endmodule

/* File: rtl/i2c_host_port.sv */
// host end of the two-wire link: runs register write and combined read transfers
// assumes the sensor end never stretches the clock line
`timescale 1ns/1ps
`include "reg_access_cfg.svh"
module i2c_host_port (
    input wire logic clock,
    input wire logic reset,
    i2c_link_if.master link,
    input wire logic cmd_start,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_count,
    input wire logic [7:0] wr_data,
    output logic wr_take,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic busy,
    output logic done,
    output logic ack_error
);
    localparam logic [6:0] QCYC = 7'(`SCL_QUARTER_CYC);

    typedef struct packed {
        reg_access_pkg::master_state_t st;
        reg_access_pkg::byte_kind_t kind;
        logic [1:0] q;
        logic [6:0] div;
        logic [3:0] bit_i;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] remain;
        logic read_op;
        logic [7:0] reg_a;
        logic nak;
        logic scl_oe_n;
        logic sda_oe_n;
        logic sda_s1;
        logic sda_s2;
        logic busy;
        logic done;
        logic err;
        logic rd_valid;
        logic [7:0] rd_data;
        logic wr_take;
    } host_t;

    host_t r;
    host_t n;
    logic tick;

    assign tick = (r.div == QCYC - 7'h01);

    always_comb begin
        n = r;
        n.sda_s1 = link.sda_line;
        n.sda_s2 = r.sda_s1;
        n.done = 1'b0;
        n.rd_valid = 1'b0;
        n.wr_take = 1'b0;
        n.div = tick ? 7'h00 : r.div + 7'h01;
        if (tick && r.st != reg_access_pkg::M_IDLE) begin
            n.q = r.q + 2'h1;
        end
        case (r.st)
            reg_access_pkg::M_IDLE: begin
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = 1'b1;
                n.q = 2'h0;
                if (cmd_start) begin
                    n.busy = 1'b1;
                    n.err = 1'b0;
                    n.read_op = cmd_read;
                    n.reg_a = cmd_reg;
                    n.remain = cmd_count;
                    n.tx = `DEV_ADDR_BYTE_WR;
                    n.kind = reg_access_pkg::K_ADDRW;
                    n.div = 7'h00;
                    n.st = reg_access_pkg::M_START;
                end
            end
            reg_access_pkg::M_START: begin
                if (tick) begin
                    case (r.q)
                        2'h0: n.sda_oe_n = 1'b1;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b0;
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.bit_i = 4'h0;
                            n.st = reg_access_pkg::M_BIT;
                        end
                    endcase
                end
            end
            reg_access_pkg::M_BIT: begin
                if (tick) begin
                    case (r.q)
                        2'h0: begin
                            if (r.bit_i < 4'h8) begin
                                n.sda_oe_n = (r.kind == reg_access_pkg::K_READ) ? 1'b1 : r.tx[7];
                                n.tx = {r.tx[6:0], 1'b0};
                            end else if (r.kind == reg_access_pkg::K_READ) begin
                                n.sda_oe_n = (r.remain == 8'h01);
                            end else begin
                                n.sda_oe_n = 1'b1;
                            end
                        end
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: begin
                            if (r.bit_i < 4'h8) begin
                                n.rx = {r.rx[6:0], r.sda_s2};
                            end else begin
                                n.nak = r.sda_s2;
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.bit_i = r.bit_i + 4'h1;
                            if (r.bit_i == 4'h8) begin
                                n.bit_i = 4'h0;
                                if (r.kind != reg_access_pkg::K_READ && r.nak) begin
                                    n.err = 1'b1;
                                    n.st = reg_access_pkg::M_STOP;
                                end else begin
                                    case (r.kind)
                                        reg_access_pkg::K_ADDRW: begin
                                            n.tx = r.reg_a;
                                            n.kind = reg_access_pkg::K_REG;
                                        end
                                        reg_access_pkg::K_REG: begin
                                            if (r.read_op) begin
                                                n.tx = `DEV_ADDR_BYTE_RD;
                                                n.kind = reg_access_pkg::K_ADDRR;
                                                n.st = reg_access_pkg::M_START;
                                            end else begin
                                                n.tx = wr_data;
                                                n.wr_take = 1'b1;
                                                n.kind = reg_access_pkg::K_DATA;
                                            end
                                        end
                                        reg_access_pkg::K_DATA: begin
                                            n.remain = r.remain - 8'h01;
                                            if (r.remain == 8'h01) begin
                                                n.st = reg_access_pkg::M_STOP;
                                            end else begin
                                                n.tx = wr_data;
                                                n.wr_take = 1'b1;
                                            end
                                        end
                                        reg_access_pkg::K_ADDRR: begin
                                            n.kind = reg_access_pkg::K_READ;
                                        end
                                        default: begin
                                            n.rd_data = r.rx;
                                            n.rd_valid = 1'b1;
                                            n.remain = r.remain - 8'h01;
                                            if (r.remain == 8'h01) begin
                                                n.st = reg_access_pkg::M_STOP;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tick) begin
                    case (r.q)
                        2'h0: n.sda_oe_n = 1'b0;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b1;
                        default: begin
                            n.busy = 1'b0;
                            n.done = 1'b1;
                            n.st = reg_access_pkg::M_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r <= '0;
            r.st <= reg_access_pkg::M_IDLE;
            r.kind <= reg_access_pkg::K_ADDRW;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.m_scl_o = 1'b0;
    assign link.m_sda_o = 1'b0;
    assign link.m_scl_oe_n = r.scl_oe_n;
    assign link.m_sda_oe_n = r.sda_oe_n;
    assign wr_take = r.wr_take;
    assign rd_valid = r.rd_valid;
    assign rd_data = r.rd_data;
    assign busy = r.busy;
    assign done = r.done;
    assign ack_error = r.err;
endmodule

/* File: testbench/i2c_link_props.sv */
// checker on the two-wire link between host end and sensor end
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
module i2c_link_props (
    input wire logic clock,
    input wire logic reset,
    input wire logic m_scl_o,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_o,
    input wire logic s_sda_oe_n,
    input wire logic scl_line,
    input wire logic sda_line
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence start_seen;
        $fell(sda_line) && scl_line && $past(scl_line);
    endsequence
    sequence stop_seen;
        $rose(sda_line) && scl_line && $past(scl_line);
    endsequence
    a_sensor_od_level: assert property (s_sda_o == 1'h0) else $error("sensor sda level");
    a_host_od_level: assert property (!m_scl_o && !m_sda_o) else $error("host line level");
    a_sda_still_hi: assert property (scl_line && $past(scl_line) |-> $stable(s_sda_oe_n)) else $error("sda moved");
    a_one_driver: assert property (scl_line |-> m_sda_oe_n || s_sda_oe_n) else $error("two sda drivers");
    a_start_free: assert property (start_seen |-> s_sda_oe_n) else $error("sensor held start");
    a_stop_release: assert property (stop_seen |=> s_sda_oe_n [*8]) else $error("sensor after stop");
    a_scl_low_span: assert property ($fell(scl_line) |=> !scl_line [*8]) else $error("scl low short");
    a_scl_high_span: assert property ($rose(scl_line) |=> scl_line [*8]) else $error("scl high short");
endmodule

/* File: testbench/tb_i2c_register_access_update.sv */
// bench: host end drives sensor end, registers seen at the user port
// assumes rtl files and the link checker compiled first
`timescale 1ns/1ps
module tb_i2c_register_access_update;
    logic clock = 1'h0, reset = 1'h1, cmd_start = 1'h0, cmd_read = 1'h0, aev_event = 1'h0, autov_event = 1'h0;
    logic [7:0] cmd_reg = 8'h00, cmd_count = 8'h01, user_addr = 8'h00, user_data, rd_data, wq [4], rq [4];
    logic wr_take, rd_valid, done, ack_error, aev_commit, autov_commit, link_busy, host_busy;
    logic [3:0] ctl;
    int err_count = 0, num_checks = 0, cyc = 0, wi = 0, ri = 0;
    i2c_link_if link();
    i2c_host_port i2c_host_port_i(.clock(clock), .reset(reset), .link(link), .cmd_start(cmd_start),
        .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_count(cmd_count), .wr_data(wq[wi]), .wr_take(wr_take),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(host_busy), .done(done), .ack_error(ack_error));
    i2c_sensor_port i2c_sensor_port_i(.clock(clock), .reset(reset), .link(link), .aev_event(aev_event),
        .autov_event(autov_event), .user_addr(user_addr), .user_data(user_data),
        .aev_commit(aev_commit), .autov_commit(autov_commit), .ctl(ctl), .link_busy(link_busy),
        .wr_strobe(), .wr_addr(), .wr_data());
    i2c_link_props i2c_link_props_i(.clock(clock), .reset(reset), .m_scl_o(link.m_scl_o), .m_sda_o(link.m_sda_o),
        .m_sda_oe_n(link.m_sda_oe_n), .s_sda_o(link.s_sda_o), .s_sda_oe_n(link.s_sda_oe_n),
        .scl_line(link.scl_line), .sda_line(link.sda_line));
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wr_take) wi <= wi + 1;
        if (rd_valid) begin
            rq[ri] <= rd_data;
            ri <= ri + 1;
        end
        if (cyc == 70000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic rd, input logic [7:0] a, input logic [7:0] n);
        cmd_read = rd;
        cmd_reg = a;
        cmd_count = n;
        wi = 0;
        ri = 0;
        cmd_start = 1'h1;
        #25;
        cmd_start = 1'h0;
        for (int i = 0; i < 30000 && done !== 1'h1; i++) #25;
        check({7'h00, done}, 8'h01);
        check({7'h00, ack_error}, 8'h00);
        check({6'h00, host_busy, link_busy}, 8'h00);
    endtask
    task automatic peek(input logic [7:0] a, input logic [7:0] exp);
        user_addr = a;
        #50;
        check(user_data, exp);
    endtask
    task automatic t_sync_write();
        wq = '{8'hA5, 8'h3C, 8'h00, 8'h00};
        run(1'h0, 8'h4F, 8'h02);
        peek(8'h4F, 8'h00);
        check({7'h00, aev_commit}, 8'h00);
        aev_event = 1'h1;
        #25;
        aev_event = 1'h0;
        check({7'h00, aev_commit}, 8'h01);
        peek(8'h4F, 8'hA5);
        peek(8'h50, 8'h00);
        $display("sync write done");
    endtask
    task automatic t_regular();
        wq = '{8'h77, 8'h08, 8'h00, 8'h00};
        run(1'h0, 8'h22, 8'h02);
        peek(8'h22, 8'h77);
        check({4'h0, ctl}, 8'h08);
        peek(8'h50, 8'h3C);
        aev_event = 1'h1;
        #25;
        aev_event = 1'h0;
        check({6'h00, aev_commit, autov_commit}, 8'h01);
        $display("regular write done");
    endtask
    task automatic t_read();
        run(1'h1, 8'h22, 8'h02);
        check(rq[0], 8'h77);
        check(rq[1], 8'h08);
        $display("read done");
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        #1;
        reset = 1'h0;
        #100;
        t_sync_write();
        t_regular();
        t_read();
        end_of_test();
    end
endmodule
